/* File: include/hvsc_pkg.sv */
// Shared constants for the high-voltage driver serial configuration block
package hvsc_pkg;

   // ************************************************************
   // Serial word layout
   // ************************************************************
   localparam int WORD_W      = 24;
   localparam int SEL_BIT     = 0;
   localparam int LVL_LSB     = 1;
   localparam int LVL_W       = 3;
   localparam int LIM_LSB     = 4;
   localparam int LIM_W       = 2;
   localparam int SS_OFF_BIT  = 6;
   localparam int SYNC_BIT    = 7;
   localparam int LIM_OFF_BIT = 8;
   localparam int MASK_LSB    = 1;
   localparam int LINE_OUTS   = 21;
   localparam int BOOST_OUTS  = 19;

   // ************************************************************
   // Reset values and implemented-bit masks
   // ************************************************************
   localparam logic [WORD_W-1:0] CFG_RESET      = 24'h00_0000;
   localparam logic [WORD_W-1:0] MASK_RESET     = 24'h00_0000;
   localparam logic [WORD_W-1:0] SHIFT_RESET    = 24'h00_0000;
   localparam logic [WORD_W-1:0] CFG_IMPL_MASK  = 24'h00_01fe;
   localparam logic [WORD_W-1:0] LINE_OUT_MASK  = 24'h3f_fffe;
   localparam logic [WORD_W-1:0] BOOST_OUT_MASK = 24'h0f_fffe;

   // ************************************************************
   // Field codes
   // ************************************************************
   localparam logic [LVL_W-1:0] LEVEL_SHUTDOWN = 3'h0;
   localparam logic [LIM_W-1:0] LIMIT_200MA    = 2'h0;
   localparam logic [LIM_W-1:0] LIMIT_600MA    = 2'h1;
   localparam logic [LIM_W-1:0] LIMIT_1A       = 2'h2;
   localparam logic [LIM_W-1:0] LIMIT_OVER_1A5 = 2'h3;

   // ************************************************************
   // Pin synchroniser layout and timing
   // ************************************************************
   localparam int PIN_N     = 6;
   localparam int PIN_SCLK  = 0;
   localparam int PIN_SDATA = 1;
   localparam int PIN_STB_N = 2;
   localparam int PIN_PWM   = 3;
   localparam int PIN_GATE  = 4;
   localparam int PIN_TGT   = 5;
   localparam logic [PIN_N-1:0] PIN_RESET = 6'h04;
   localparam int SOFTSTART_PWM_CYCLES    = 16384;

   // Boost regulator states
   typedef enum logic [3:0] {
      HVSC_REG_OFF    = 4'b0001,
      HVSC_REG_SWITCH = 4'b0010,
      HVSC_REG_WAIT   = 4'b0100,
      HVSC_REG_HOLD   = 4'b1000
   } hvsc_reg_state_t;

endpackage

/* File: rtl/hvsc_softstart.sv */
// Soft-start interval counter clocked by boost PWM rising edges
`timescale 1ns/1ps
module hvsc_softstart #(
   parameter int CYCLES = hvsc_pkg::SOFTSTART_PWM_CYCLES
)(
   // System
   input  wire logic i_clk_sys,
   input  wire logic i_sys_rst,
   // Control
   input  wire logic i_start,
   input  wire logic i_abort,
   input  wire logic i_pwm_rise,
   // Status
   output logic      o_active
);
   localparam int CNT_W = $clog2(CYCLES) + 1;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

   logic [CNT_W-1:0] count;

   // ************************************************************
   // Interval counter
   // ************************************************************
   // Start restarts a running interval; abort ends it at once
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_active <= 1'b0;
         count    <= '0;
      end else if (i_start) begin
         o_active <= 1'b1;
         count    <= '0;
      end else if (i_abort) begin
         o_active <= 1'b0;
         count    <= '0;
      end else if (o_active && i_pwm_rise) begin
         if (count == LAST) begin
            o_active <= 1'b0;
            count    <= '0;
         end else begin
            count <= count + CNT_W'(1);
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   chk_ss_expire: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_active && i_pwm_rise && count == LAST && !i_start |=> !o_active)
      else $error("soft start did not end after its last PWM cycle");
   chk_ss_holds: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_active && !i_abort && !(i_pwm_rise && count == LAST) |=> o_active)
      else $error("soft start ended early");
   chk_ss_restart: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_start |=> o_active && count == '0)
      else $error("soft start did not restart");
   cov_ss_done: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_active ##1 !o_active);

endmodule

/* File: rtl/hvsc_top.sv */
// Serial configuration, output latching and boost control of the HV driver
`timescale 1ns/1ps
// Summary of operation
// - Reset clears shift register, both latched words and all control state.
// - 24-bit shift register moves toward MSB; first bit ends highest.
// - Strobe high: serial clock and data ignored, shift register unchanged.
// - Data sampled on each serial clock falling edge while strobe low.
// - Strobe rising edge copies shift register into word chosen by LSB.
// - Strobe falling edge clears shift register and re-enables input.
// - Latched words hold until same-type word arrives or reset.
// - LSB zero selects configuration word, one selects output mask.
// - Bit 8 disables current limit outside soft start; bits 23..9 read zero.
// - Bit 7 delays regulator switch-off to next PWM rising edge.
// - Bit 6 bypasses soft start, using selected limit directly.
// - Bits 5..4 pick limit 200 mA, 600 mA, 1 A, over 1.5 A.
// - Bits 3..1 zero means shutdown, outputs floating; else level.
// - Line-driver variant: any nonzero level code is just normal mode.
// - Mask bits 21..1 set each output latch; bits 23..22 read zero.
// - Line driver has 21 mask bits, boost variant only 19.
// - Soft start holds 200 mA limit for 16384 PWM cycles.
// - Lowering level while active enables discharge until level reached.
// - Gate low grounds outputs; gate high drives masked outputs high.
// - Shutdown or soft start: gate ignored, outputs floating.
module hvsc_top #(
   parameter bit BOOST_VARIANT    = 1'b1,
   parameter int SOFTSTART_CYCLES = hvsc_pkg::SOFTSTART_PWM_CYCLES
)(
   // System
   input  wire logic        i_clk_sys,
   input  wire logic        i_sys_rst,
   // Serial pins
   input  wire logic        i_serial_clk,
   input  wire logic        i_serial_data,
   input  wire logic        i_load_strobe_n,
   // Boost and output gate pins
   input  wire logic        i_boost_pwm_in,
   input  wire logic        i_output_gate,
   input  wire logic        i_vpp_at_target,
   // High-voltage outputs
   output logic [20:0]      o_hv_outputs,
   output logic [20:0]      o_hv_outputs_oe,
   // Boost control
   output logic             o_boost_switch,
   output logic             o_discharge_en,
   output logic [1:0]       o_current_limit_sel,
   output logic             o_current_limit_off,
   output logic [2:0]       o_boost_level_sel,
   output logic             o_softstart_active,
   output logic             o_normal_mode,
   // Latched words
   output logic [23:0]      o_config_word,
   output logic [23:0]      o_mask_word
);

   // Implemented output-mask bits for a variant
   function automatic logic [hvsc_pkg::WORD_W-1:0] out_mask(input bit boost);
      out_mask = boost ? hvsc_pkg::BOOST_OUT_MASK : hvsc_pkg::LINE_OUT_MASK;
   endfunction

   // Level field of a word
   function automatic logic [hvsc_pkg::LVL_W-1:0] level_of(input logic [hvsc_pkg::WORD_W-1:0] w);
      level_of = w[hvsc_pkg::LVL_LSB +: hvsc_pkg::LVL_W];
   endfunction

   localparam logic [hvsc_pkg::WORD_W-1:0] OUT_MASK = out_mask(BOOST_VARIANT);

   logic [hvsc_pkg::PIN_N-1:0]  pin_meta;
   logic [hvsc_pkg::PIN_N-1:0]  pin_sync;
   logic [hvsc_pkg::PIN_N-1:0]  pin_prev;
   logic [hvsc_pkg::WORD_W-1:0] shift;
   logic [hvsc_pkg::WORD_W-1:0] config_word;
   logic [hvsc_pkg::WORD_W-1:0] mask_word;
   logic                        sclk_fall;
   logic                        strobe_fall;
   logic                        strobe_rise;
   logic                        strobe_low;
   logic                        pwm_rise;
   logic                        vpp_at_target;
   logic                        cfg_load;
   logic                        mask_load;
   logic [hvsc_pkg::LVL_W-1:0]  level;
   logic [hvsc_pkg::LVL_W-1:0]  new_level;
   logic                        ss_start;
   logic                        ss_abort;
   logic                        ss_active;
   logic                        outputs_float;
   hvsc_pkg::hvsc_reg_state_t   reg_state;
   hvsc_pkg::hvsc_reg_state_t   next_reg_state;

   // ************************************************************
   // Pin synchronisers and edge detection
   // ************************************************************
   // Three flops per pin; edges compare the second and third stages
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         pin_meta <= hvsc_pkg::PIN_RESET;
         pin_sync <= hvsc_pkg::PIN_RESET;
         pin_prev <= hvsc_pkg::PIN_RESET;
      end else begin
         pin_meta <= {i_vpp_at_target, i_output_gate, i_boost_pwm_in,
                      i_load_strobe_n, i_serial_data, i_serial_clk};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // Data and clock see equal delay, so data set while clock high is settled at the fall
   assign sclk_fall     = pin_prev[hvsc_pkg::PIN_SCLK] & ~pin_sync[hvsc_pkg::PIN_SCLK];
   assign strobe_fall   = pin_prev[hvsc_pkg::PIN_STB_N] & ~pin_sync[hvsc_pkg::PIN_STB_N];
   assign strobe_rise   = ~pin_prev[hvsc_pkg::PIN_STB_N] & pin_sync[hvsc_pkg::PIN_STB_N];
   assign strobe_low    = ~pin_sync[hvsc_pkg::PIN_STB_N];
   assign pwm_rise      = ~pin_prev[hvsc_pkg::PIN_PWM] & pin_sync[hvsc_pkg::PIN_PWM];
   assign vpp_at_target = pin_sync[hvsc_pkg::PIN_TGT];

   // ************************************************************
   // Serial shift register
   // ************************************************************
   // Strobe edge outranks a clock edge seen in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         shift <= hvsc_pkg::SHIFT_RESET;
      end else if (strobe_fall) begin
         shift <= hvsc_pkg::SHIFT_RESET;
      end else if (strobe_low && sclk_fall) begin
         shift <= {shift[hvsc_pkg::WORD_W-2:0], pin_sync[hvsc_pkg::PIN_SDATA]};
      end
   end

   // ************************************************************
   // Word latching
   // ************************************************************
   assign cfg_load  = strobe_rise & ~shift[hvsc_pkg::SEL_BIT];
   assign mask_load = strobe_rise & shift[hvsc_pkg::SEL_BIT];
   assign new_level = level_of(shift);
   assign level     = level_of(config_word);

   // Unimplemented bits are dropped at latch time so they always read zero
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         config_word <= hvsc_pkg::CFG_RESET;
      end else if (cfg_load) begin
         config_word <= shift & hvsc_pkg::CFG_IMPL_MASK;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         mask_word <= hvsc_pkg::MASK_RESET;
      end else if (mask_load) begin
         mask_word <= shift & OUT_MASK;
      end
   end

   assign o_config_word = config_word;
   assign o_mask_word   = mask_word;

   // ************************************************************
   // Soft start
   // ************************************************************
   // Only the boost variant has an inrush interval to manage
   assign ss_start = cfg_load & BOOST_VARIANT & (level == hvsc_pkg::LEVEL_SHUTDOWN)
                     & (new_level != hvsc_pkg::LEVEL_SHUTDOWN) & ~shift[hvsc_pkg::SS_OFF_BIT];
   assign ss_abort = cfg_load & ((new_level == hvsc_pkg::LEVEL_SHUTDOWN) | shift[hvsc_pkg::SS_OFF_BIT]);

   hvsc_softstart #(
      .CYCLES     (SOFTSTART_CYCLES)
   ) u_softstart (
      .i_clk_sys  (i_clk_sys),
      .i_sys_rst  (i_sys_rst),
      .i_start    (ss_start),
      .i_abort    (ss_abort),
      .i_pwm_rise (pwm_rise),
      .o_active   (ss_active)
   );

   // ************************************************************
   // Boost regulator release
   // ************************************************************
   // Off at target: at once, or on the next PWM rise when sync is set
   always_comb begin
      next_reg_state = reg_state;
      unique case (reg_state)
         hvsc_pkg::HVSC_REG_OFF: begin
            if (BOOST_VARIANT && level != hvsc_pkg::LEVEL_SHUTDOWN) begin
               next_reg_state = hvsc_pkg::HVSC_REG_SWITCH;
            end
         end
         hvsc_pkg::HVSC_REG_SWITCH: begin
            if (level == hvsc_pkg::LEVEL_SHUTDOWN) begin
               next_reg_state = hvsc_pkg::HVSC_REG_OFF;
            end else if (vpp_at_target) begin
               next_reg_state = config_word[hvsc_pkg::SYNC_BIT] ? hvsc_pkg::HVSC_REG_WAIT
                                                                : hvsc_pkg::HVSC_REG_HOLD;
            end
         end
         hvsc_pkg::HVSC_REG_WAIT: begin
            if (level == hvsc_pkg::LEVEL_SHUTDOWN) begin
               next_reg_state = hvsc_pkg::HVSC_REG_OFF;
            end else if (pwm_rise) begin
               next_reg_state = hvsc_pkg::HVSC_REG_HOLD;
            end else if (!vpp_at_target) begin
               next_reg_state = hvsc_pkg::HVSC_REG_SWITCH;
            end
         end
         hvsc_pkg::HVSC_REG_HOLD: begin
            if (level == hvsc_pkg::LEVEL_SHUTDOWN) begin
               next_reg_state = hvsc_pkg::HVSC_REG_OFF;
            end else if (!vpp_at_target) begin
               next_reg_state = hvsc_pkg::HVSC_REG_SWITCH;
            end
         end
         default: next_reg_state = hvsc_pkg::HVSC_REG_OFF;
      endcase
   end

   // Switch follows the PWM only while the next state is switching or waiting
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         reg_state      <= hvsc_pkg::HVSC_REG_OFF;
         o_boost_switch <= 1'b0;
      end else begin
         reg_state      <= next_reg_state;
         o_boost_switch <= pin_sync[hvsc_pkg::PIN_PWM] & ((next_reg_state == hvsc_pkg::HVSC_REG_SWITCH)
                           | (next_reg_state == hvsc_pkg::HVSC_REG_WAIT));
      end
   end

   // ************************************************************
   // Rail discharge
   // ************************************************************
   // A lowering write wins over a target-reached clear in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_discharge_en <= 1'b0;
      end else if (cfg_load && BOOST_VARIANT && level != hvsc_pkg::LEVEL_SHUTDOWN && new_level < level) begin
         o_discharge_en <= 1'b1;
      end else if (cfg_load && new_level > level) begin
         o_discharge_en <= 1'b0;
      end else if (!vpp_at_target) begin
         o_discharge_en <= 1'b0;
      end
   end

   // ************************************************************
   // Limit, level and output drive
   // ************************************************************
   assign outputs_float = (level == hvsc_pkg::LEVEL_SHUTDOWN) | ss_active;

   // Soft start overrides both the limit selection and its disable
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_current_limit_sel <= hvsc_pkg::LIMIT_200MA;
         o_current_limit_off <= 1'b0;
         o_boost_level_sel   <= hvsc_pkg::LEVEL_SHUTDOWN;
         o_normal_mode       <= 1'b0;
         o_softstart_active  <= 1'b0;
      end else begin
         o_current_limit_sel <= ss_active ? hvsc_pkg::LIMIT_200MA
                                          : config_word[hvsc_pkg::LIM_LSB +: hvsc_pkg::LIM_W];
         o_current_limit_off <= config_word[hvsc_pkg::LIM_OFF_BIT] & ~ss_active;
         o_boost_level_sel   <= BOOST_VARIANT ? level : hvsc_pkg::LEVEL_SHUTDOWN;
         o_normal_mode       <= level != hvsc_pkg::LEVEL_SHUTDOWN;
         o_softstart_active  <= ss_active;
      end
   end

   // Unimplemented outputs are never enabled
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_hv_outputs    <= '0;
         o_hv_outputs_oe <= '0;
      end else begin
         o_hv_outputs_oe <= outputs_float ? '0 : OUT_MASK[hvsc_pkg::MASK_LSB +: hvsc_pkg::LINE_OUTS];
         o_hv_outputs    <= (outputs_float || !pin_sync[hvsc_pkg::PIN_GATE]) ? '0
                            : mask_word[hvsc_pkg::MASK_LSB +: hvsc_pkg::LINE_OUTS];
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   chk_por_clear: assert property (disable iff (1'b0) i_sys_rst |=>
      shift == '0 && config_word == '0 && mask_word == '0 && o_hv_outputs_oe == '0)
      else $error("reset left state behind");
   chk_strobe_ignore: assert property (!strobe_low && !strobe_fall |=> $stable(shift))
      else $error("shift register moved while strobe high");
   chk_shift_in: assert property (strobe_low && sclk_fall && !strobe_fall |=>
      shift == {$past(shift[22:0]), $past(pin_sync[hvsc_pkg::PIN_SDATA])})
      else $error("bit not shifted in at the low end");
   chk_fall_clear: assert property (strobe_fall |=> shift == '0)
      else $error("strobe fall did not clear shift register");
   chk_cfg_latch: assert property (cfg_load |=> config_word == ($past(shift) & hvsc_pkg::CFG_IMPL_MASK))
      else $error("configuration word not latched");
   chk_mask_latch: assert property (mask_load |=> mask_word == ($past(shift) & out_mask(BOOST_VARIANT)))
      else $error("output mask not latched");
   chk_words_hold: assert property (!strobe_rise |=> $stable(config_word) && $stable(mask_word))
      else $error("latched word changed without a load");
   chk_gate_low: assert property (!pin_sync[hvsc_pkg::PIN_GATE] |=> o_hv_outputs == '0)
      else $error("output driven high with gate low");
   chk_float: assert property (outputs_float |=> o_hv_outputs_oe == '0)
      else $error("outputs enabled in shutdown or soft start");
   chk_soft_limit: assert property (ss_active |=> o_current_limit_sel == hvsc_pkg::LIMIT_200MA)
      else $error("limit not held during soft start");
   chk_async_off: assert property (reg_state == hvsc_pkg::HVSC_REG_SWITCH && vpp_at_target &&
      !config_word[hvsc_pkg::SYNC_BIT] && level != hvsc_pkg::LEVEL_SHUTDOWN |=> !o_boost_switch)
      else $error("regulator still switching at target");
   chk_sync_wait: assert property (reg_state == hvsc_pkg::HVSC_REG_WAIT && !pwm_rise && vpp_at_target
      && level != hvsc_pkg::LEVEL_SHUTDOWN |=> reg_state == hvsc_pkg::HVSC_REG_WAIT)
      else $error("synchronised release left before PWM rise");
   chk_discharge_set: assert property (cfg_load && BOOST_VARIANT && level != hvsc_pkg::LEVEL_SHUTDOWN
      && new_level < level |=> o_discharge_en)
      else $error("discharge not enabled on lowering");
   chk_discharge_raise: assert property (cfg_load && new_level > level |=> !o_discharge_en)
      else $error("discharge enabled on raising");

   cov_cfg_load: cover property (cfg_load ##1 level != hvsc_pkg::LEVEL_SHUTDOWN);
   cov_mask_load: cover property (mask_load ##[1:8] o_hv_outputs != '0);
   cov_discharge: cover property (o_discharge_en ##1 !o_discharge_en);
   cov_sync_release: cover property (reg_state == hvsc_pkg::HVSC_REG_WAIT ##1 reg_state == hvsc_pkg::HVSC_REG_HOLD);

endmodule

/* File: testbench/hvsc_host_model.sv */
// Host controller model for the serial pins
`timescale 1ns/1ps
module hvsc_host_model (
   // Timing reference
   input  wire logic i_clk_sys,
   // Serial pins
   output logic      o_serial_clk,
   output logic      o_serial_data,
   output logic      o_load_strobe_n
);
   // ****
   // Frame driver
   // ****
   // Idle pins: strobe high, clock low
   initial begin
      o_serial_clk = 1'b0;
      o_serial_data = 1'b0;
      o_load_strobe_n = 1'b1;
   end
   // MSB first; stb=0 clocks with strobe held high
   task automatic send_word(input logic [31:0] w, input int n, input bit stb);
      @(negedge i_clk_sys);
      o_load_strobe_n = !stb;
      #32;
      for (int i = n - 1; i >= 0; i--) begin
         o_serial_clk = 1'b1;
         #16 o_serial_data = w[i];
         #16 o_serial_clk = 1'b0;
         #32;
      end
      o_load_strobe_n = 1'b1;
      // Released data line must not keep its value
      #8 o_serial_data = !o_serial_data;
   endtask
endmodule

/* File: testbench/hvsc_top_test.sv */
// Self-checking bench for the HV driver serial block
`timescale 1ns/1ps
module hvsc_top_test;
   // ****
   // Pins and bookkeeping
   // ****
   logic        clk, rst, pwm, gate, tgt, sclk, sdat, stb_n;
   logic        sw, dis, lim_off, ss, norm, l_sw, l_norm;
   logic [1:0]  lim;
   logic [2:0]  lvl, l_lvl;
   logic [20:0] hv, hv_oe, l_oe;
   logic [23:0] cfg, msk, w, m_exp, l_msk;
   int          err_total, checks_done, seed;
   // Soft start shortened to 8 PWM rises
   hvsc_top #(.BOOST_VARIANT(1'b1), .SOFTSTART_CYCLES(8)) i_hvsc_top (
      .i_clk_sys(clk), .i_sys_rst(rst), .i_serial_clk(sclk), .i_serial_data(sdat),
      .i_load_strobe_n(stb_n), .i_boost_pwm_in(pwm), .i_output_gate(gate),
      .i_vpp_at_target(tgt), .o_hv_outputs(hv), .o_hv_outputs_oe(hv_oe),
      .o_boost_switch(sw), .o_discharge_en(dis), .o_current_limit_sel(lim),
      .o_current_limit_off(lim_off), .o_boost_level_sel(lvl),
      .o_softstart_active(ss), .o_normal_mode(norm), .o_config_word(cfg), .o_mask_word(msk));
   // Line-driver variant listens on the same serial pins
   hvsc_top #(.BOOST_VARIANT(1'b0), .SOFTSTART_CYCLES(8)) i_hvsc_top_line (
      .i_clk_sys(clk), .i_sys_rst(rst), .i_serial_clk(sclk), .i_serial_data(sdat),
      .i_load_strobe_n(stb_n), .i_boost_pwm_in(pwm), .i_output_gate(gate),
      .i_vpp_at_target(tgt), .o_hv_outputs(), .o_hv_outputs_oe(l_oe),
      .o_boost_switch(l_sw), .o_discharge_en(), .o_current_limit_sel(),
      .o_current_limit_off(), .o_boost_level_sel(l_lvl),
      .o_softstart_active(), .o_normal_mode(l_norm), .o_config_word(), .o_mask_word(l_msk));
   hvsc_host_model i_hvsc_host_model (
      .i_clk_sys(clk), .o_serial_clk(sclk), .o_serial_data(sdat), .o_load_strobe_n(stb_n));
   // Clock 250 MHz
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ****
   // Helpers
   // ****
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Load waits past the sync and latch delay
   task automatic load(input logic [31:0] v, input int n);
      i_hvsc_host_model.send_word(v, n, 1'b1);
      repeat (10) @(negedge clk);
   endtask
   function automatic logic [23:0] exp_hv(input logic [23:0] m, input logic g);
      return g ? (m >> 1) : 24'h00_0000;
   endfunction
   task automatic pwm_rises(input int n);
      repeat (n) begin
         pwm = 1'b1;
         repeat (4) @(negedge clk);
         pwm = 1'b0;
         repeat (4) @(negedge clk);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog well past the expected 25 us
   initial begin
      #200000;
      err_total++;
      stop_test();
   end
   // ****
   // Scenarios
   // ****
   initial begin
      {rst, pwm, gate, tgt} = 4'b1000;
      err_total = 0;
      checks_done = 0;
      seed = 32'h29a4_ea68;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      check(cfg, 24'h00_0000);
      check(msk | 24'(hv_oe), 24'h00_0000);
      $display("test reset done");
      // Random masks while shut down; outputs stay floating
      for (int k = 0; k < 3; k++) begin
         w = 24'($random(seed)) | 24'h00_0001;
         load(32'(w), 24);
         m_exp = w & hvsc_pkg::BOOST_OUT_MASK;
         check(msk, m_exp);
         check(l_msk, w & hvsc_pkg::LINE_OUT_MASK);
         check(cfg | 24'(hv_oe), 24'h00_0000);
      end
      $display("test mask done");
      // Every limit code, soft start bypassed, rising levels
      gate = 1'b1;
      for (int k = 0; k < 4; k++) begin
         w = 24'($random(seed));
         {w[6:4], w[3:1], w[0]} = {1'b1, 2'(k), 3'(k + 1), 1'b0};
         load(32'(w), 24);
         check(cfg, w & hvsc_pkg::CFG_IMPL_MASK);
         check({lim_off, lim, lvl, norm, ss}, {w[8], w[5:4], w[3:1], 2'b10});
         check(24'(hv_oe), hvsc_pkg::BOOST_OUT_MASK >> 1);
         check(24'(hv), exp_hv(m_exp, 1'b1));
      end
      check({l_norm, l_lvl, l_sw}, 24'h00_0010);
      check(24'(l_oe), hvsc_pkg::LINE_OUT_MASK >> 1);
      gate = 1'b0;
      repeat (6) @(negedge clk);
      check(24'(hv), exp_hv(m_exp, 1'b0));
      $display("test config done");
      // Clocking with strobe high, then an over-long burst
      i_hvsc_host_model.send_word(32'hffff_ffff, 24, 1'b0);
      repeat (10) @(negedge clk);
      check(msk, m_exp);
      load({8'hff, 24'h2a_5a5b} ^ 32'hc000_0000, 30);
      check(msk, 24'h2a_5a5b & hvsc_pkg::BOOST_OUT_MASK);
      $display("test framing done");
      // Lower then raise level while active
      tgt = 1'b1;
      load(32'h0000_0044, 24);
      check(24'(dis), 24'h00_0001);
      load(32'h0000_004c, 24);
      check(24'(dis), 24'h00_0000);
      $display("test discharge done");
      // Shutdown, then restart with soft start
      load(32'h0000_0000, 24);
      check({norm, 21'(hv_oe)}, 22'h0);
      load(32'h0000_0126, 24);
      check({ss, lim, lim_off}, 4'h8);
      check(24'(hv_oe), 24'h00_0000);
      pwm_rises(7);
      check(24'(ss), 24'h00_0001);
      pwm_rises(1);
      repeat (4) @(negedge clk);
      check({ss, lim, lim_off}, 4'b0101);
      check(24'(hv_oe), hvsc_pkg::BOOST_OUT_MASK >> 1);
      $display("test softstart done");
      // Release at target: at once first, then held for the next PWM rise
      pwm = 1'b1;
      for (int k = 0; k < 2; k++) begin
         tgt = 1'b0;
         repeat (6) @(negedge clk);
         check(24'(sw), 24'h00_0001);
         tgt = 1'b1;
         repeat (6) @(negedge clk);
         check(24'(sw), 24'(k));
         load(32'h0000_01a6, 24);
      end
      pwm = 1'b0;
      repeat (4) @(negedge clk);
      pwm = 1'b1;
      repeat (6) @(negedge clk);
      check(24'(sw), 24'h00_0000);
      $display("test release done");
      stop_test();
   end
endmodule
